// [shared/rk_pkg.sv]
// rk_pkg: shared constants and types of the rotary knob peripheral
package rk_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int RK_CLK_PERIOD_NS = 4;
  localparam int RK_MS_UNIT_NS = 1000000;
  localparam int RK_MS_CYCLES = RK_MS_UNIT_NS / RK_CLK_PERIOD_NS;
  localparam int RK_DETENTS_PER_REV = 24;
  localparam int RK_EDGES_PER_DETENT = 4;
  localparam logic [15:0] RK_WAIT_DEFAULT = 16'h00FA;
  localparam logic [15:0] RK_WAIT_MIN = 16'h0001;
  localparam logic [15:0] RK_WAIT_MAX = 16'hFDE8;
  localparam logic [15:0] RK_ELAPSED_MAX = 16'hFFFF;
  // ****************************************
  // target address
  // ****************************************
  localparam logic [6:0] RK_ADDR_DEFAULT = 7'h3F;
  localparam logic [6:0] RK_ADDR_STRAP = 7'h3E;
  localparam logic [6:0] RK_ADDR_LOW = 7'h08;
  localparam logic [6:0] RK_ADDR_HIGH = 7'h77;
  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam logic [5:0] RK_OFS_STATUS = 6'h00;
  localparam logic [5:0] RK_OFS_GATE = 6'h04;
  localparam logic [5:0] RK_OFS_STEP = 6'h08;
  localparam logic [5:0] RK_OFS_ELAPSED = 6'h0C;
  localparam logic [5:0] RK_OFS_WAIT = 6'h10;
  localparam logic [5:0] RK_OFS_COLOUR = 6'h14;
  localparam logic [5:0] RK_OFS_ADDR = 6'h18;
  localparam logic [5:0] RK_OFS_DETENT = 6'h1C;
  localparam logic [1:0] RK_GATE_RESET = 2'h3;
  localparam logic [2:0] RK_FLAG_MASK = 3'h7;
  localparam logic [1:0] RK_RESP_OKAY = 2'h0;
  localparam logic [1:0] RK_RESP_DECERR = 2'h3;
  localparam int RK_STRAP_BIT = 8;

  typedef struct packed {
    logic held;
    logic click;
    logic press_irq;
    logic knob_irq;
  } rk_status_t;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } rk_colour_t;

  typedef enum logic [5:0] {
    RK_I2_IDLE = 6'b000001,
    RK_I2_ADDR = 6'b000010,
    RK_I2_ACK = 6'b000100,
    RK_I2_WRITE = 6'b001000,
    RK_I2_READ = 6'b010000,
    RK_I2_RDACK = 6'b100000
  } rk_i2c_state_t;
endpackage : rk_pkg

// [hdl/rk_pwm.sv]
// rk_pwm: one pulse-width modulated light channel
module rk_pwm
  import rk_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [WIDTH-1:0] duty,
  output logic pwm
);
  logic [WIDTH-1:0] phase;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      phase <= '0;
    end else begin
      phase <= phase + 1'b1;
    end
  end

  // full scale stays one count short of always-on
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pwm <= 1'b0;
    end else begin
      pwm <= (phase < duty);
    end
  end
endmodule : rk_pwm

// [hdl/rk_knob.sv]
// rk_knob: rotary knob peripheral with i2c target and axi4-lite registers
module rk_knob
  import rk_pkg::*;
#(
  parameter int MS_CYCLES = RK_MS_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic rst_pin_n,
  input wire logic knob_a,
  input wire logic knob_b,
  input wire logic button,
  input wire logic addr_strap,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic int_o,
  output logic int_oe,
  output logic irq,
  output logic led_red,
  output logic led_green,
  output logic led_blue,
  input wire rk_colour_t nvm_colour,
  output rk_colour_t nvm_wr_data,
  output logic nvm_wr_valid,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ****************************************
  // input synchronisers
  // ****************************************
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  logic [NSYNC-1:0] raw_in;
  logic core_rst;
  logic pin_rst_n, qa, qb, btn, strap, scl, sda;

  assign raw_in = {rst_pin_n, knob_a, knob_b, button, addr_strap, scl_i, sda_i};
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= raw_in;
      sync_b <= sync_a;
    end
  end
  assign {pin_rst_n, qa, qb, btn, strap, scl, sda} = sync_b;
  assign core_rst = rst | ~pin_rst_n;

  // ****************************************
  // millisecond tick
  // ****************************************
  localparam int MSW = $clog2(MS_CYCLES);
  logic [MSW-1:0] ms_div;
  logic ms_tick;
  always_ff @(posedge clk_sys) begin
    if (core_rst || ms_tick) begin
      ms_div <= '0;
    end else begin
      ms_div <= ms_div + 1'b1;
    end
  end
  assign ms_tick = (ms_div == MSW'(MS_CYCLES - 1));

  // ****************************************
  // quadrature decode
  // ****************************************
  logic [1:0] q_prev;
  logic [2:0] sub_cnt;
  logic q_up, q_dn, step_up, step_dn, moved;
  logic signed [15:0] step_total;
  logic [4:0] detent_pos;
  localparam logic [2:0] SUB_TOP = 3'(RK_EDGES_PER_DETENT - 1);
  localparam logic [4:0] POS_TOP = 5'(RK_DETENTS_PER_REV - 1);

  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      q_prev <= 2'h0;
    end else begin
      q_prev <= {qa, qb};
    end
  end
  // gray sequence 00-01-11-10 counts up
  assign q_up = ({q_prev, qa, qb} == 4'h1) || ({q_prev, qa, qb} == 4'h7) ||
                ({q_prev, qa, qb} == 4'hE) || ({q_prev, qa, qb} == 4'h8);
  assign q_dn = ({q_prev, qa, qb} == 4'h2) || ({q_prev, qa, qb} == 4'hB) ||
                ({q_prev, qa, qb} == 4'hD) || ({q_prev, qa, qb} == 4'h4);
  assign step_up = q_up && (sub_cnt == SUB_TOP);
  assign step_dn = q_dn && (sub_cnt == -SUB_TOP);
  assign moved = step_up | step_dn;

  always_ff @(posedge clk_sys) begin
    if (core_rst || moved) begin
      sub_cnt <= 3'h0;
    end else if (q_up) begin
      sub_cnt <= sub_cnt + 3'h1;
    end else if (q_dn) begin
      sub_cnt <= sub_cnt - 3'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      detent_pos <= 5'h00;
    end else if (step_up) begin
      detent_pos <= (detent_pos == POS_TOP) ? 5'h00 : detent_pos + 5'h01;
    end else if (step_dn) begin
      detent_pos <= (detent_pos == 5'h00) ? POS_TOP : detent_pos - 5'h01;
    end
  end

  // ****************************************
  // register bus
  // ****************************************
  logic aw_full, w_full, wr_go, rd_go;
  logic [5:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  rk_status_t status;
  logic [1:0] irq_gate;
  logic [15:0] idle_elapsed_ms, knob_idle_wait_ms, wait_cnt, wr_wait;
  rk_colour_t colour;
  logic [6:0] sw_addr, eff_addr;
  logic wr_step, wr_elapsed, wr_colour, wr_stat;

  assign s_axi_awready = !aw_full && !s_axi_bvalid;
  assign s_axi_wready = !w_full && !s_axi_bvalid;
  assign wr_go = aw_full && w_full && !s_axi_bvalid;
  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      aw_full <= 1'b0;
      aw_addr <= 6'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_full <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      w_full <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_go) begin
      w_full <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RK_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr > RK_OFS_DETENT || aw_addr[1:0] != 2'h0) ?
                     RK_RESP_DECERR : RK_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
  // only full-word writes change state; partial strobes are taken and ignored
  assign wr_stat = wr_go && (w_strb == 4'hF);
  assign wr_step = wr_stat && aw_addr == RK_OFS_STEP;
  assign wr_elapsed = wr_stat && aw_addr == RK_OFS_ELAPSED;
  assign wr_colour = wr_stat && aw_addr == RK_OFS_COLOUR;
  assign wr_wait = (w_data[15:0] < RK_WAIT_MIN) ? RK_WAIT_MIN :
                   (w_data[15:0] > RK_WAIT_MAX) ? RK_WAIT_MAX : w_data[15:0];

  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      irq_gate <= RK_GATE_RESET;
      knob_idle_wait_ms <= RK_WAIT_DEFAULT;
      sw_addr <= RK_ADDR_DEFAULT;
    end else if (wr_stat) begin
      if (aw_addr == RK_OFS_GATE) begin
        irq_gate <= w_data[1:0];
      end
      if (aw_addr == RK_OFS_WAIT) begin
        knob_idle_wait_ms <= wr_wait;
      end
      if (aw_addr == RK_OFS_ADDR && w_data[6:0] >= RK_ADDR_LOW &&
          w_data[6:0] <= RK_ADDR_HIGH) begin
        sw_addr <= w_data[6:0];
      end
    end
  end
  assign eff_addr = strap ? RK_ADDR_STRAP : sw_addr;

  assign s_axi_arready = !s_axi_rvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RK_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RK_RESP_OKAY;
      unique case (s_axi_araddr)
        RK_OFS_STATUS: s_axi_rdata <= {28'h0, status};
        RK_OFS_GATE: s_axi_rdata <= {30'h0, irq_gate};
        RK_OFS_STEP: s_axi_rdata <= {{16{step_total[15]}}, step_total};
        RK_OFS_ELAPSED: s_axi_rdata <= {16'h0, idle_elapsed_ms};
        RK_OFS_WAIT: s_axi_rdata <= {16'h0, knob_idle_wait_ms};
        RK_OFS_COLOUR: s_axi_rdata <= {8'h0, colour};
        RK_OFS_ADDR: s_axi_rdata <= {23'h0, strap, 1'b0, eff_addr};
        RK_OFS_DETENT: s_axi_rdata <= {27'h0, detent_pos};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= RK_RESP_DECERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // step count and idle timing
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      step_total <= 16'sh0000;
    end else if (wr_step) begin
      step_total <= w_data[15:0];
    end else if (step_up) begin
      step_total <= step_total + 16'sh0001;
    end else if (step_dn) begin
      step_total <= step_total - 16'sh0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (core_rst || moved) begin
      idle_elapsed_ms <= 16'h0000;
    end else if (wr_elapsed) begin
      idle_elapsed_ms <= w_data[15:0];
    end else if (ms_tick && idle_elapsed_ms != RK_ELAPSED_MAX) begin
      idle_elapsed_ms <= idle_elapsed_ms + 16'h0001;
    end
  end

  logic turn_pending, knob_fire;
  assign knob_fire = turn_pending && !moved && (wait_cnt >= knob_idle_wait_ms);
  always_ff @(posedge clk_sys) begin
    if (core_rst || moved) begin
      wait_cnt <= 16'h0000;
    end else if (turn_pending && ms_tick) begin
      wait_cnt <= wait_cnt + 16'h0001;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      turn_pending <= 1'b0;
    end else if (moved) begin
      turn_pending <= 1'b1;
    end else if (knob_fire) begin
      turn_pending <= 1'b0;
    end
  end

  // ****************************************
  // button and interrupt status
  // ****************************************
  logic btn_prev, btn_edge, btn_release;
  logic [2:0] w1c;
  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      btn_prev <= 1'b0;
    end else begin
      btn_prev <= btn;
    end
  end
  assign btn_edge = btn ^ btn_prev;
  assign btn_release = btn_prev && !btn;
  assign w1c = (wr_stat && aw_addr == RK_OFS_STATUS) ? w_data[2:0] & RK_FLAG_MASK : 3'h0;

  // a new event in the clearing cycle keeps its flag
  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      status <= '0;
    end else begin
      status.held <= btn;
      status.click <= (status.click & ~w1c[2]) | btn_release;
      status.press_irq <= (status.press_irq & ~w1c[1]) | btn_edge;
      status.knob_irq <= (status.knob_irq & ~w1c[0]) | knob_fire;
    end
  end

  assign irq = |({status.press_irq, status.knob_irq} & irq_gate);
  assign int_o = 1'b0;
  assign int_oe = irq;

  // ****************************************
  // light colour and nvm
  // ****************************************
  logic restored;
  // nvm contents are taken once after reset release, never under reset
  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      restored <= 1'b0;
      colour <= '0;
    end else if (!restored) begin
      restored <= 1'b1;
      colour <= nvm_colour;
    end else if (wr_colour) begin
      colour <= w_data[23:0];
    end
  end
  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      nvm_wr_valid <= 1'b0;
      nvm_wr_data <= '0;
    end else begin
      nvm_wr_valid <= wr_colour && restored;
      nvm_wr_data <= w_data[23:0];
    end
  end

  rk_pwm #(.WIDTH(8)) u_pwm_red (.clk_sys(clk_sys), .rst(core_rst),
    .duty(colour.red), .pwm(led_red));
  rk_pwm #(.WIDTH(8)) u_pwm_green (.clk_sys(clk_sys), .rst(core_rst),
    .duty(colour.green), .pwm(led_green));
  rk_pwm #(.WIDTH(8)) u_pwm_blue (.clk_sys(clk_sys), .rst(core_rst),
    .duty(colour.blue), .pwm(led_blue));

  // ****************************************
  // i2c target: acks its address, reads return status
  // ****************************************
  rk_i2c_state_t i2_state;
  logic scl_d, sda_d, scl_rise, scl_fall, i2_start, i2_stop, i2_rw;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl;
      sda_d <= sda;
    end
  end
  assign scl_rise = scl && !scl_d;
  assign scl_fall = !scl && scl_d;
  assign i2_start = scl && scl_d && sda_d && !sda;
  assign i2_stop = scl && scl_d && !sda_d && sda;
  assign sda_o = 1'b0;

  always_ff @(posedge clk_sys) begin
    if (core_rst || i2_stop) begin
      i2_state <= RK_I2_IDLE;
      sda_oe <= 1'b0;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      i2_rw <= 1'b0;
    end else if (i2_start) begin
      i2_state <= RK_I2_ADDR;
      sda_oe <= 1'b0;
      bit_cnt <= 4'h0;
    end else begin
      unique case (i2_state)
        RK_I2_IDLE: sda_oe <= 1'b0;
        RK_I2_ADDR, RK_I2_WRITE: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'h8) begin
            bit_cnt <= 4'h0;
            if (i2_state == RK_I2_WRITE || shreg[7:1] == eff_addr) begin
              i2_state <= RK_I2_ACK;
              sda_oe <= 1'b1;
              if (i2_state == RK_I2_ADDR) begin
                i2_rw <= shreg[0];
              end
            end else begin
              i2_state <= RK_I2_IDLE;
            end
          end
        end
        RK_I2_ACK, RK_I2_RDACK: begin
          if (scl_rise && i2_state == RK_I2_RDACK) begin
            i2_rw <= !sda;
          end else if (scl_fall) begin
            if (i2_rw) begin
              i2_state <= RK_I2_READ;
              shreg <= {4'h0, status};
              sda_oe <= 1'b1;
            end else begin
              i2_state <= (i2_state == RK_I2_ACK) ? RK_I2_WRITE : RK_I2_IDLE;
              sda_oe <= 1'b0;
            end
          end
        end
        RK_I2_READ: begin
          if (scl_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt == 4'h8) begin
              bit_cnt <= 4'h0;
              sda_oe <= 1'b0;
              i2_state <= RK_I2_RDACK;
            end else begin
              shreg <= {shreg[6:0], 1'b0};
              sda_oe <= !shreg[6];
            end
          end
        end
      endcase
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (core_rst);

  AST_DETENT_WRAP: assert property (step_up && detent_pos == POS_TOP |=> detent_pos == 5'h00)
    else $error("detent position did not wrap");
  AST_STEP_DOWN: assert property (step_dn && !wr_step |=> step_total == $past(step_total) - 16'sh0001)
    else $error("step count did not decrement");
  AST_PIN_RESET: assert property (disable iff (rst) !pin_rst_n |=> status == '0 && !irq)
    else $error("pin reset did not hold block");
  AST_INT_DRIVE: assert property (int_oe == irq && !int_o)
    else $error("interrupt pin drive wrong");
  AST_BTN_IRQ: assert property (btn_edge |=> status.press_irq ##0 status.held == $past(btn))
    else $error("button edge lost");
  AST_IDLE_FIRE: assert property ($rose(status.knob_irq) |-> $past(wait_cnt >= knob_idle_wait_ms))
    else $error("knob interrupt before timeout");
  AST_WAIT_RANGE: assert property (knob_idle_wait_ms >= RK_WAIT_MIN && knob_idle_wait_ms <= RK_WAIT_MAX)
    else $error("idle timeout out of range");
  AST_ADDR_DEFAULT: assert property (!strap && $past(core_rst) |-> eff_addr == RK_ADDR_DEFAULT)
    else $error("default address wrong");
  AST_ADDR_STRAP: assert property (strap |-> eff_addr == RK_ADDR_STRAP)
    else $error("strap address not forced");
  AST_ADDR_RANGE: assert property (sw_addr >= RK_ADDR_LOW && sw_addr <= RK_ADDR_HIGH)
    else $error("software address out of range");
  AST_PWM_OFF: assert property (colour.red == 8'h00 && $past(colour.red) == 8'h00 |-> !led_red)
    else $error("red channel lit at zero");
  AST_NVM_SAVE: assert property (wr_colour && restored |=> nvm_wr_valid && nvm_wr_data == colour)
    else $error("colour not saved");
  AST_GATE: assert property (irq == ((status.press_irq && irq_gate[1]) || (status.knob_irq && irq_gate[0])))
    else $error("interrupt gating wrong");
  AST_CLICK: assert property (btn_release |=> status.click)
    else $error("click not flagged");
  AST_STEP_WRITE: assert property (wr_step |=> step_total == $past(w_data[15:0]))
    else $error("step write lost");
  AST_ELAPSED_SAT: assert property (idle_elapsed_ms == RK_ELAPSED_MAX && !moved && !wr_elapsed |=> idle_elapsed_ms == RK_ELAPSED_MAX)
    else $error("elapsed time wrapped");

  COV_STEP: cover property (step_up ##[1:200] step_dn);
  COV_KNOB_IRQ: cover property (moved ##[1:1000] $rose(status.knob_irq));
  COV_I2C_ACK: cover property (i2_state == RK_I2_ACK && sda_oe);
  COV_AXI_WR: cover property (wr_go ##1 s_axi_bvalid);
endmodule : rk_knob

// [tb/rk_i2c_host.sv]
// rk_i2c_host: i2c host model that probes a target address
module rk_i2c_host (
  input wire logic clk_sys,
  input wire logic sda_line,
  output logic scl,
  output logic sda_pull
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx;
  // a quarter of the 160 ns scl period
  task automatic q();
    repeat (10) @(posedge clk_sys);
  endtask : q
  // sda moves only while scl is low, so no false start or stop
  task automatic bit_slot(input logic pull, output logic seen);
    scl <= 1'b0;
    q();
    sda_pull <= pull;
    q();
    scl <= 1'b1;
    q();
    seen = sda_line;
    q();
  endtask : bit_slot
  task automatic probe(input logic [6:0] addr, input logic rw, output logic ack);
    logic [7:0] b;
    logic s;
    b = {addr, rw};
    sda_pull <= 1'b1;
    q();
    for (int i = 7; i >= 0; i--) bit_slot(!b[i], s);
    bit_slot(1'b0, s);
    ack = !s;
    // a read takes one byte and ends it with a nack
    if (rw && ack) begin
      for (int i = 7; i >= 0; i--) begin
        bit_slot(1'b0, s);
        rx[i] = s;
      end
      bit_slot(1'b0, s);
    end
    bit_slot(1'b1, s);
    sda_pull <= 1'b0;
    q();
  endtask : probe
  // scl stands high between frames
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
endmodule : rk_i2c_host

// [tb/rotary_knob_i2c_peripheral_tb.sv]
// rotary_knob_i2c_peripheral_tb: self-checking bench of the knob peripheral
module rotary_knob_i2c_peripheral_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rk_pkg::*;
  // ****************
  // signals
  // ****************
  localparam int MS = 20;
  logic clk_sys, rst, rst_pin_n, knob_a, knob_b, button, addr_strap, scl, host_pull, ack;
  logic sda_o, sda_oe, int_o, int_oe, irq, led_red, led_green, led_blue, nvm_wr_valid;
  rk_colour_t nvm_colour, nvm_wr_data, nvm_seen;
  logic [5:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int n [3];
  // open drain: a line is low only while some side enables a low drive
  wire logic sda_line = !host_pull && !(sda_oe && !sda_o);
  wire logic int_line = !(int_oe && !int_o);
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
  $display("unexpected at %0t: got %0h want %0h", $time, a, b); end end
  rk_knob #(.MS_CYCLES(MS)) dut (.clk_sys, .rst, .rst_pin_n, .knob_a, .knob_b, .button,
    .addr_strap, .scl_i(scl), .sda_i(sda_line), .sda_o, .sda_oe, .int_o, .int_oe, .irq,
    .led_red, .led_green, .led_blue, .nvm_colour, .nvm_wr_data, .nvm_wr_valid, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  rk_i2c_host host (.clk_sys, .sda_line, .scl, .sda_pull(host_pull));
  // ****************
  // clock, timeout and tasks
  // ****************
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (nvm_wr_valid) nvm_seen <= nvm_wr_data;
    if (cyc == 20000) begin
      err_count++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results
  task automatic wt(input int c);
    repeat (c) @(negedge clk_sys);
  endtask : wt
  // ready and answer are looked at mid-cycle, acted on at the next rising edge
  task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
    {s_axi_arvalid, s_axi_rready} <= {2{!w}};
    forever begin
      @(negedge clk_sys);
      ta = w ? s_axi_awready : s_axi_arready;
      tw = s_axi_wready;
      tb = w ? s_axi_bvalid : s_axi_rvalid;
      rd = s_axi_rdata;
      rs = w ? s_axi_bresp : s_axi_rresp;
      @(posedge clk_sys);
      if (ta) {s_axi_awvalid, s_axi_arvalid} <= 2'b00;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) break;
    end
    {s_axi_bready, s_axi_rready} <= 2'b00;
    @(negedge clk_sys);
  endtask : acc
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [5:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask : rdc
  // whole detents, four gray steps each
  task automatic turn(input logic up, input int k);
    logic [1:0] p;
    repeat (k) for (int i = 0; i < 4; i++) begin
      p = up ? 2'(i + 1) : 2'(3 - i);
      @(posedge clk_sys);
      {knob_a, knob_b} <= {p[1], p[1] ^ p[0]};
      repeat (3) @(posedge clk_sys);
    end
    wt(1);
  endtask : turn
  // ****************
  // tests
  // ****************
  initial begin
    {rst, rst_pin_n, knob_a, knob_b, button, addr_strap} = 6'b110000;
    nvm_colour = 24'h123456;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 44'h0;
    s_axi_wstrb = 4'hF;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    wt(3);
    rdc(RK_OFS_GATE, 32'h3);
    rdc(RK_OFS_WAIT, 32'hFA);
    rdc(RK_OFS_STATUS, 32'h0);
    rdc(RK_OFS_COLOUR, 32'h123456);
    rdc(RK_OFS_ADDR, 32'h3F);
    rdc(6'h20, 32'h0);
    `CHK(rs, RK_RESP_DECERR)
    wr(6'h06, 32'h0);
    `CHK(rs, RK_RESP_DECERR)
    $display("test reset values done");
    wr(RK_OFS_WAIT, 32'h0);
    rdc(RK_OFS_WAIT, 32'h1);
    wr(RK_OFS_WAIT, 32'hFFFF);
    rdc(RK_OFS_WAIT, 32'hFDE8);
    wr(RK_OFS_WAIT, 32'h3);
    `CHK(rs, RK_RESP_OKAY)
    turn(1'b1, 24);
    rdc(RK_OFS_STEP, 32'd24);
    rdc(RK_OFS_DETENT, 32'd0);
    turn(1'b0, 2);
    // next detent must land before the earliest idle fire, three ms ticks on
    wt(20);
    `CHK(irq, 1'b0)
    turn(1'b1, 1);
    wt(30);
    `CHK(irq, 1'b0)
    wt(40);
    `CHK(irq, 1'b1)
    `CHK(int_line, 1'b0)
    rdc(RK_OFS_STATUS, 32'h1);
    rdc(RK_OFS_STEP, 32'd23);
    rdc(RK_OFS_DETENT, 32'd23);
    wr(RK_OFS_ELAPSED, 32'h0);
    acc(1'b0, RK_OFS_ELAPSED, 32'h0);
    `CHK(rd < 2, 1'b1)
    wr(RK_OFS_STATUS, 32'h1);
    `CHK(int_line, 1'b1)
    $display("test knob done");
    wr(RK_OFS_GATE, 32'h1);
    @(posedge clk_sys);
    button <= 1'b1;
    wt(8);
    `CHK(irq, 1'b0)
    rdc(RK_OFS_STATUS, 32'hA);
    host.probe(RK_ADDR_DEFAULT, 1'b1, ack);
    `CHK(ack, 1'b1)
    `CHK(host.rx, 8'h0A)
    wr(RK_OFS_GATE, 32'h3);
    `CHK(irq, 1'b1)
    wr(RK_OFS_STATUS, 32'h2);
    @(posedge clk_sys);
    button <= 1'b0;
    wt(8);
    rdc(RK_OFS_STATUS, 32'h6);
    wr(RK_OFS_STATUS, 32'h7);
    `CHK(irq, 1'b0)
    wr(RK_OFS_STEP, 32'h8000);
    rdc(RK_OFS_STEP, 32'hFFFF8000);
    $display("test button and count done");
    wr(RK_OFS_COLOUR, 32'hFF8001);
    wt(2);
    `CHK(nvm_seen, 24'hFF8001)
    n = '{0, 0, 0};
    repeat (256) begin
      @(negedge clk_sys);
      n = '{n[0] + led_red, n[1] + led_green, n[2] + led_blue};
    end
    `CHK(n[0], 255)
    `CHK(n[1], 128)
    `CHK(n[2], 1)
    $display("test light done");
    host.probe(RK_ADDR_DEFAULT, 1'b0, ack);
    `CHK(ack, 1'b1)
    host.probe(RK_ADDR_STRAP, 1'b0, ack);
    `CHK(ack, 1'b0)
    wr(RK_OFS_ADDR, 32'h50);
    host.probe(7'h50, 1'b0, ack);
    `CHK(ack, 1'b1)
    wr(RK_OFS_ADDR, 32'h78);
    rdc(RK_OFS_ADDR, 32'h50);
    wr(RK_OFS_ADDR, 32'h08);
    @(posedge clk_sys);
    addr_strap <= 1'b1;
    wt(4);
    rdc(RK_OFS_ADDR, 32'h13E);
    host.probe(RK_ADDR_STRAP, 1'b0, ack);
    `CHK(ack, 1'b1)
    host.probe(7'h08, 1'b0, ack);
    `CHK(ack, 1'b0)
    $display("test address done");
    wr(RK_OFS_GATE, 32'h0);
    @(posedge clk_sys);
    rst_pin_n <= 1'b0;
    nvm_colour <= 24'hA5C30F;
    wt(4);
    @(posedge clk_sys);
    rst_pin_n <= 1'b1;
    wt(5);
    rdc(RK_OFS_GATE, 32'h3);
    rdc(RK_OFS_COLOUR, 32'hA5C30F);
    $display("test pin reset done");
    results();
  end
endmodule : rotary_knob_i2c_peripheral_tb
